// file: dds_cfg.svh
// Purpose: Offsets, field positions, reset values and limits of the DDS core
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef DDS_CFG_SVH
`define DDS_CFG_SVH

// ==========================================
// Register byte offsets
`define DDS_OFF_CTRL      8'h00
`define DDS_OFF_STEP_LO   8'h04
`define DDS_OFF_STEP_HI   8'h08
`define DDS_OFF_ARB_LEN   8'h0c
`define DDS_OFF_MEM_ADDR  8'h10
`define DDS_OFF_MEM_DATA  8'h14
`define DDS_OFF_PHASE     8'h18
`define DDS_OFF_STATUS    8'h1c

// ==========================================
// Control fields
`define DDS_CTRL_FUNC_LSB 0
`define DDS_CTRL_FUNC_MSB 2
`define DDS_CTRL_CONT_BIT 3

// ==========================================
// Status fields
`define DDS_STAT_DEEP_BIT    0
`define DDS_STAT_CLAMP_BIT   1
`define DDS_STAT_ELLIP_BIT   2
`define DDS_STAT_PULSE_BIT   3

// ==========================================
// Widths and depths
`define DDS_ACC_W        64
`define DDS_SAMPLE_W     14
`define DDS_SHALLOW_AW   14
`define DDS_DEEP_AW      16
`define DDS_LEN_W        17

// ==========================================
// Reset values and limits
`define DDS_CTRL_RST     4'h8
`define DDS_LEN_RST      17'h04000
`define DDS_SHALLOW_PTS  17'h04000
`define DDS_DEEP_PTS     17'h10000
`define DDS_DAC_MID      14'h2000
// Largest step for arbitrary output: 6 MHz / 50 MHz * 2^64, rounded down
`define DDS_ARB_MAX_STEP 64'h1eb851eb851eb851

`endif

// file: dds_pkg.sv
// Purpose: Types shared by the DDS core files
// Assumes: Encodings match the control register function field
// Notes: Constants live in dds_cfg.svh
package dds_pkg;

  // ==========================================
  // Waveform functions
  typedef enum logic [2:0] {
    DDS_FN_SINE   = 3'h0,
    DDS_FN_SQUARE = 3'h1,
    DDS_FN_RAMP   = 3'h2,
    DDS_FN_PULSE  = 3'h3,
    DDS_FN_NOISE  = 3'h4,
    DDS_FN_DC     = 3'h5,
    DDS_FN_ARB    = 3'h6
  } dds_func_t;

endpackage

// file: dds_wave_mem.sv
// Purpose: Waveform sample memory, one write port and one registered read port
// Assumes: Single clock, write and read may target the same word
// Notes: Read data appears one edge after the address
`timescale 1ns/100ps
module dds_wave_mem #(
  parameter int AW = 16,
  parameter int DW = 14
) (
  input wire logic core_clk, // Sample clock
  input wire logic wr_en, // Write strobe
  input wire logic [AW-1:0] wr_addr, // Write address
  input wire logic [DW-1:0] wr_data, // Write sample
  input wire logic [AW-1:0] rd_addr, // Read address
  output logic [DW-1:0] rd_data // Registered read sample
);

  // ==========================================
  // Storage, no reset so it maps to block RAM
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // dds_wave_mem

// file: dds_core.sv
// Purpose: DDS phase accumulator, waveform memory addressing and DAC sample stream
// Assumes: One 50 MHz sample clock, APB slave for all software control
// Notes: Phase to DAC latency is three clock edges
//
// Behaviour
// RL1 - Every clock the phase step is added to the accumulator and the sum stored back.
// RL2 - Accumulator and phase step are both 64 bits wide.
// RL3 - The memory address is taken only from the top 14 or top 16 accumulator bits.
// RL4 - Standard waveforms and arbitrary ones up to 16K points use a 16K word memory.
// RL5 - Arbitrary waveforms over 16K points use a 64K word memory with a 16-bit address.
// RL6 - One sample is read each 50 MHz clock and sent to the converter in sequence.
// RL7 - Each sample is a 14-bit code choosing one of 16,384 output levels.
// RL8 - One waveform cycle spans the whole selected memory, shorter records repeat points.
// RL9 - Loading a new phase step never touches the accumulated phase.
// RL10 - All functions use the memory path except pulse, which hands over to its own generator.
// RL11 - Arbitrary waveforms of any length up to 65,536 points are accepted.
// RL12 - Arbitrary output frequency is limited to 6 MHz.
// RL13 - The elliptical filter is chosen only for continuous sine, otherwise linear phase.
// RL14 - Reset clears the accumulator so output starts at the first memory word.
//
// The address map and the APB register port were decided locally.
`include "dds_cfg.svh"
`timescale 1ns/100ps
module dds_core #(
  parameter int ACC_W = `DDS_ACC_W,
  parameter int SAMPLE_W = `DDS_SAMPLE_W,
  parameter int SHALLOW_AW = `DDS_SHALLOW_AW,
  parameter int DEEP_AW = `DDS_DEEP_AW,
  parameter int LEN_W = `DDS_LEN_W
) (
  input wire logic core_clk, // 50 MHz sample clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high for write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output logic [SAMPLE_W-1:0] dac_code, // Sample code to the converter
  output logic filter_ellip_sel, // High picks elliptical filter
  output logic pulse_gen_sel, // High hands output to pulse generator
  output logic mem_deep // High while 64K word memory is in use
);

  // ==========================================
  // Register state
  logic [ACC_W-1:0] phase_acc_r;
  logic [ACC_W-1:0] phase_acc_nxt;
  logic [ACC_W-1:0] phase_step_register_r;
  logic [31:0] step_lo_pend_r;
  logic [3:0] ctrl_r;
  logic [LEN_W-1:0] arb_len_r;
  logic [DEEP_AW-1:0] mem_wr_addr_r;
  logic [DEEP_AW-1:0] point_idx_r;
  logic [SAMPLE_W-1:0] dac_code_r;
  logic pulse_sel_d1_r;
  logic pulse_sel_d2_r;
  logic ellip_r;
  logic pulse_r;
  logic deep_r;

  // ==========================================
  // APB decode
  wire logic apb_setup_or_acc = psel;
  wire logic apb_access = psel & penable;
  wire logic apb_wr = apb_access & pwrite;
  wire logic apb_rd = apb_access & ~pwrite;
  wire logic hit_ctrl = (paddr == `DDS_OFF_CTRL);
  wire logic hit_step_lo = (paddr == `DDS_OFF_STEP_LO);
  wire logic hit_step_hi = (paddr == `DDS_OFF_STEP_HI);
  wire logic hit_len = (paddr == `DDS_OFF_ARB_LEN);
  wire logic hit_maddr = (paddr == `DDS_OFF_MEM_ADDR);
  wire logic hit_mdata = (paddr == `DDS_OFF_MEM_DATA);
  wire logic hit_phase = (paddr == `DDS_OFF_PHASE);
  wire logic hit_status = (paddr == `DDS_OFF_STATUS);
  wire logic hit_any = hit_ctrl | hit_step_lo | hit_step_hi | hit_len |
                       hit_maddr | hit_mdata | hit_phase | hit_status;

  wire logic wr_ctrl = apb_wr & hit_ctrl;
  wire logic wr_step_lo = apb_wr & hit_step_lo;
  wire logic wr_step_hi = apb_wr & hit_step_hi;
  wire logic wr_len = apb_wr & hit_len;
  wire logic wr_maddr = apb_wr & hit_maddr;
  wire logic wr_mdata = apb_wr & hit_mdata;

  // ==========================================
  // Control fields
  wire dds_pkg::dds_func_t func =
    dds_pkg::dds_func_t'(ctrl_r[`DDS_CTRL_FUNC_MSB:`DDS_CTRL_FUNC_LSB]);
  wire logic cont = ctrl_r[`DDS_CTRL_CONT_BIT];
  wire logic is_arb = (func == dds_pkg::DDS_FN_ARB);
  wire logic is_sine = (func == dds_pkg::DDS_FN_SINE);
  wire logic is_pulse = (func == dds_pkg::DDS_FN_PULSE);

  // Only arbitrary records longer than 16K points need the deep memory
  wire logic deep_sel = is_arb & (arb_len_r > `DDS_SHALLOW_PTS); // RL4 RL5

  // ==========================================
  // Arbitrary length write, clamped to the deep memory size
  wire logic [LEN_W-1:0] len_wr_raw = pwdata[LEN_W-1:0];
  wire logic len_wr_over = (pwdata > {15'h0000, `DDS_DEEP_PTS});
  wire logic len_wr_zero = (pwdata == 32'h0000_0000);
  wire logic [LEN_W-1:0] len_wr_val = len_wr_over ? `DDS_DEEP_PTS : // RL11
                                      len_wr_zero ? {{(LEN_W-1){1'b0}}, 1'b1} :
                                      len_wr_raw;

  // ==========================================
  // Effective step: arbitrary output is held at or below 6 MHz
  wire logic step_over = is_arb & (phase_step_register_r > `DDS_ARB_MAX_STEP);
  wire logic [ACC_W-1:0] step_eff = step_over ? `DDS_ARB_MAX_STEP : // RL12
                                    phase_step_register_r;

  // Step writes never reach the accumulator, so phase stays continuous
  assign phase_acc_nxt = phase_acc_r + step_eff; // RL1 RL2 RL9

  // ==========================================
  // Memory addressing from the top accumulator bits only
  wire logic [SHALLOW_AW-1:0] phase_shallow =
    phase_acc_r[ACC_W-1 -: SHALLOW_AW]; // RL3
  wire logic [DEEP_AW-1:0] phase_deep = phase_acc_r[ACC_W-1 -: DEEP_AW]; // RL3
  wire logic [DEEP_AW-1:0] phase_sel = deep_sel ? phase_deep :
    {{(DEEP_AW-SHALLOW_AW){1'b0}}, phase_shallow};

  // Scale phase by record length so one record fills one full cycle
  wire logic [DEEP_AW+LEN_W-1:0] scaled = phase_sel * arb_len_r; // RL8
  wire logic [DEEP_AW-1:0] arb_idx_deep = scaled[DEEP_AW+DEEP_AW-1:DEEP_AW];
  wire logic [DEEP_AW-1:0] arb_idx_shallow =
    scaled[SHALLOW_AW+DEEP_AW-1:SHALLOW_AW];
  wire logic [DEEP_AW-1:0] arb_idx = deep_sel ? arb_idx_deep : arb_idx_shallow;

  // Standard tables are always 16K points, no scaling needed
  wire logic [DEEP_AW-1:0] std_idx = {{(DEEP_AW-SHALLOW_AW){1'b0}}, phase_shallow}; // RL4
  wire logic [DEEP_AW-1:0] point_idx_nxt = is_arb ? arb_idx : std_idx;

  // ==========================================
  // Waveform memory
  logic [SAMPLE_W-1:0] mem_rd_data;

  dds_wave_mem #(
    .AW(DEEP_AW),
    .DW(SAMPLE_W)
  ) u_wave_mem (
    .core_clk(core_clk),
    .wr_en(wr_mdata),
    .wr_addr(mem_wr_addr_r),
    .wr_data(pwdata[SAMPLE_W-1:0]), // RL7
    .rd_addr(point_idx_r),
    .rd_data(mem_rd_data)
  );

  // Pulse bypasses the memory path, so the converter rests at midscale
  wire logic [SAMPLE_W-1:0] dac_code_nxt = pulse_sel_d2_r ? `DDS_DAC_MID : // RL10
                                           mem_rd_data; // RL6

  // ==========================================
  // Filter and output routing
  wire logic ellip_nxt = is_sine & cont; // RL13
  wire logic pulse_nxt = is_pulse; // RL10

  // ==========================================
  // Phase accumulator
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_acc_r <= {ACC_W{1'b0}}; // RL14
    end else begin
      phase_acc_r <= phase_acc_nxt; // RL1
    end
  end

  // ==========================================
  // Sample pipeline: index, memory read, converter register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      point_idx_r <= {DEEP_AW{1'b0}};
      pulse_sel_d1_r <= 1'b0;
      pulse_sel_d2_r <= 1'b0;
      dac_code_r <= `DDS_DAC_MID;
    end else begin
      point_idx_r <= point_idx_nxt; // RL3
      pulse_sel_d1_r <= pulse_nxt;
      pulse_sel_d2_r <= pulse_sel_d1_r;
      dac_code_r <= dac_code_nxt; // RL6
    end
  end

  // ==========================================
  // Output selects, registered to avoid glitches at the analog switches
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ellip_r <= 1'b0;
      pulse_r <= 1'b0;
      deep_r <= 1'b0;
    end else begin
      ellip_r <= ellip_nxt; // RL13
      pulse_r <= pulse_nxt; // RL10
      deep_r <= deep_sel; // RL5
    end
  end

  // ==========================================
  // Control and length registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `DDS_CTRL_RST;
      arb_len_r <= `DDS_LEN_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= pwdata[3:0];
      end
      if (wr_len) begin
        arb_len_r <= len_wr_val; // RL11
      end
    end
  end

  // ==========================================
  // Phase step, low half held until the high half lands
  // Both halves load together so the rate never takes a torn value
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_lo_pend_r <= 32'h0000_0000;
      phase_step_register_r <= {ACC_W{1'b0}};
    end else begin
      if (wr_step_lo) begin
        step_lo_pend_r <= pwdata;
      end
      if (wr_step_hi) begin
        phase_step_register_r <= {pwdata, step_lo_pend_r}; // RL2 RL9
      end
    end
  end

  // ==========================================
  // Memory write pointer, steps after each sample write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_wr_addr_r <= {DEEP_AW{1'b0}};
    end else if (wr_maddr) begin
      mem_wr_addr_r <= pwdata[DEEP_AW-1:0];
    end else if (wr_mdata) begin
      mem_wr_addr_r <= mem_wr_addr_r + {{(DEEP_AW-1){1'b0}}, 1'b1};
    end
  end

  // ==========================================
  // Read data mux
  wire logic [31:0] status_word = {28'h0000000, pulse_r, ellip_r, step_over, deep_r};
  wire logic [31:0] rd_ctrl = {28'h0000000, ctrl_r};
  wire logic [31:0] rd_step_lo = phase_step_register_r[31:0];
  wire logic [31:0] rd_step_hi = phase_step_register_r[63:32];
  wire logic [31:0] rd_len = {{(32-LEN_W){1'b0}}, arb_len_r};
  wire logic [31:0] rd_maddr = {{(32-DEEP_AW){1'b0}}, mem_wr_addr_r};
  wire logic [31:0] rd_phase = phase_acc_r[63:32];
  wire logic [31:0] rd_mux =
    hit_ctrl ? rd_ctrl :
    hit_step_lo ? rd_step_lo :
    hit_step_hi ? rd_step_hi :
    hit_len ? rd_len :
    hit_maddr ? rd_maddr :
    hit_phase ? rd_phase :
    hit_status ? status_word :
    32'h0000_0000;

  // ==========================================
  // Outputs
  // Zero-wait slave: every access completes in its first access cycle
  assign pready = apb_setup_or_acc;
  assign pslverr = apb_access & ~hit_any;
  assign prdata = apb_rd ? rd_mux : 32'h0000_0000;
  assign dac_code = dac_code_r; // RL7
  assign filter_ellip_sel = ellip_r;
  assign pulse_gen_sel = pulse_r;
  assign mem_deep = deep_r;

endmodule // dds_core

// file: dds_core_asserts.sv
// Purpose: Port checks of the DDS core
// Assumes: Zero wait APB, CTRL at 0x00, STEP at 0x04/0x08, ARB_LEN at 0x0c
// Notes: Helper flops mirror control writes
`timescale 1ns/100ps
module dds_core_asserts #(
  parameter int SAMPLE_W = 14
) (
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic [SAMPLE_W-1:0] dac_code, // Sample
  input wire logic filter_ellip_sel, // Filter pick
  input wire logic pulse_gen_sel, // Pulse pick
  input wire logic mem_deep // Deep memory
);
  // ==========
  // Mirror
  logic [3:0] ctrl_r;
  logic big_r, lo_zero_r, step_zero_r;
  logic [2:0] quiet_r;
  wire wr = psel && penable && pwrite;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= 4'h8;
      big_r <= 1'b0;
      lo_zero_r <= 1'b1;
      step_zero_r <= 1'b1;
      quiet_r <= 3'h0;
    end else begin
      if (wr && paddr == 8'h00) ctrl_r <= pwdata[3:0];
      if (wr && paddr == 8'h0c) big_r <= pwdata > 32'h4000;
      if (wr && paddr == 8'h04) lo_zero_r <= pwdata == 32'h0;
      if (wr && paddr == 8'h08) step_zero_r <= pwdata == 32'h0 && lo_zero_r;
      // Memory refresh and index moves need a quiet spell
      if (wr || !step_zero_r) quiet_r <= 3'h0;
      else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
    end
  end
  // ==========
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_ready_now: assert property (psel |-> pready)
    else $error("pready low while selected");
  a_addr_error: assert property (psel && penable && paddr[1:0] == 2'h0
    |-> pslverr == (paddr > 8'h1c)) else $error("pslverr wrong for address");
  // Selects are registered from the control word, so they trail the mirror by one edge
  a_filter_choice: assert property ($past(rst_n)
    |-> filter_ellip_sel == ($past(ctrl_r) == 4'h8)) else $error("filter select wrong");
  a_pulse_choice: assert property ($past(rst_n)
    |-> pulse_gen_sel == ($past(ctrl_r) inside {4'h3, 4'hb}))
    else $error("pulse select wrong");
  a_deep_choice: assert property ($past(rst_n)
    |-> mem_deep == ($past(ctrl_r) inside {4'h6, 4'he} && $past(big_r)))
    else $error("memory depth wrong");
  a_pulse_midscale: assert property (pulse_gen_sel [*3] |-> dac_code == 14'h2000)
    else $error("pulse output not midscale");
  a_outputs_excl: assert property (filter_ellip_sel |-> !pulse_gen_sel && !mem_deep)
    else $error("elliptical filter on wrong function");
  a_dac_hold: assert property (quiet_r == 3'h7 |-> $stable(dac_code))
    else $error("sample moved with zero step");
endmodule // dds_core_asserts

bind dds_core dds_core_asserts #(.SAMPLE_W(SAMPLE_W)) u_asserts (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .dac_code(dac_code), .filter_ellip_sel(filter_ellip_sel),
  .pulse_gen_sel(pulse_gen_sel), .mem_deep(mem_deep));

// file: dds_dac_model.sv
// Purpose: Converter model latching one code per clock
// Assumes: Codes settle before each rising edge
// Notes: Flags each latch where the level moved
`timescale 1ns/100ps
module dds_dac_model #(
  parameter int SAMPLE_W = 14
) (
  input wire logic core_clk, // Clock
  input wire logic [SAMPLE_W-1:0] dac_code, // Code in
  input wire logic filter_ellip_sel, // Filter pick
  output logic [SAMPLE_W-1:0] level_r, // Output level
  output logic moved_r, // Level changed
  output logic ellip_r // Filter in use
);
  always_ff @(posedge core_clk) begin
    level_r <= dac_code;
    moved_r <= dac_code != level_r;
    ellip_r <= filter_ellip_sel;
  end
endmodule // dds_dac_model

// file: dds_core_test.sv
// Purpose: Self-checking bench of the DDS core
// Assumes: Zero wait APB, three edge sample latency
// Notes: Stream checks rely on distinct words
`include "dds_cfg.svh"
`timescale 1ns/100ps
module dds_core_test;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic mem_deep, filter_ellip_sel, pulse_gen_sel, moved;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, ph_a, ph_b, ph_c;
  logic [13:0] dac_code, level, base;
  logic [13:0] mw [64];
  logic [13:0] exp_q [$];
  logic [31:0] lens [5] = '{32'h0, 32'h4000, 32'h4001, 32'h10000, 32'h186a0};
  int err_count, checks_done, cyc;
  dds_core dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dac_code(dac_code), .filter_ellip_sel(filter_ellip_sel),
    .pulse_gen_sel(pulse_gen_sel), .mem_deep(mem_deep));
  dds_dac_model u_dac (.core_clk(core_clk), .dac_code(dac_code),
    .filter_ellip_sel(filter_ellip_sel), .level_r(level), .moved_r(moved), .ellip_r());
  // ==========
  // Tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    if (err_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the bench watchdog ends a wait that never sees pready
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ==========
  // Clock, timeout, stream watcher
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (exp_q.size() != 0 && moved === 1'b1) check("dac", level, exp_q.pop_front());
    if (cyc == 5000) begin
      err_count++;
      conclude();
    end
  end
  // ==========
  // Sequence
  initial begin
    void'($urandom(32'h87a1));
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1, `DDS_OFF_MEM_ADDR, 32'h0);
    check("ellip", filter_ellip_sel, 1);
    base = 14'($urandom);
    for (int i = 0; i < 64; i++) begin
      mw[i] = base + 14'(i) * 14'h123;
      apb(1, `DDS_OFF_MEM_DATA, {18'h0, mw[i]});
    end
    idle(6);
    check("word0", dac_code, mw[0]);
    for (int i = 1; i <= 40; i++) exp_q.push_back(mw[i]);
    apb(1, `DDS_OFF_STEP_HI, 32'h00040000);
    idle(45);
    apb(1, `DDS_OFF_STEP_HI, 32'h0);
    check("stream", exp_q.size(), 0);
    apb(0, `DDS_OFF_PHASE, 32'h0);
    ph_a = rd;
    apb(1, `DDS_OFF_STEP_LO, 32'h80000000);
    apb(1, `DDS_OFF_STEP_HI, 32'h1);
    apb(0, `DDS_OFF_PHASE, 32'h0);
    ph_b = rd;
    apb(0, `DDS_OFF_PHASE, 32'h0);
    ph_c = rd;
    check("kept", ph_b - ph_a < 32'h9 && ph_b != ph_a, 1);
    check("rate", ph_c - ph_b inside {32'h4, 32'h5}, 1);
    for (int f = 0; f < 14; f++) begin
      apb(1, `DDS_OFF_CTRL, {28'h0, 1'(f / 7), 3'(f % 7)});
      idle(4);
      check("ellip", filter_ellip_sel, f == 7);
      check("pulse", pulse_gen_sel, f % 7 == 3);
      check("deep", mem_deep, 0);
      if (f % 7 == 3) check("mid", dac_code, `DDS_DAC_MID);
    end
    foreach (lens[i]) begin
      apb(1, `DDS_OFF_ARB_LEN, lens[i]);
      idle(2);
      check("deep", mem_deep, lens[i] > 32'h4000);
      apb(0, `DDS_OFF_ARB_LEN, 32'h0);
      check("len", rd, lens[i] == 0 ? 32'h1 : lens[i] > 32'h10000 ? 32'h10000 : lens[i]);
    end
    apb(0, 8'h20, 32'h0);
    check("err", er, 1);
    check("rdata", rd, 0);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1, `DDS_OFF_CTRL, 32'h6);
    apb(1, `DDS_OFF_ARB_LEN, 32'h4);
    idle(6);
    check("word0", dac_code, mw[0]);
    for (int i = 1; i < 8; i++) exp_q.push_back(mw[i % 4]);
    // Four points over the 16K table: each point holds four clocks, seven moves take 28
    apb(1, `DDS_OFF_STEP_HI, 32'h10000000);
    idle(36);
    check("stretch", exp_q.size(), 0);
    apb(0, `DDS_OFF_STATUS, 32'h0);
    check("clamp", rd[`DDS_STAT_CLAMP_BIT], 0);
    apb(1, `DDS_OFF_STEP_HI, 32'h20000000);
    apb(0, `DDS_OFF_STATUS, 32'h0);
    check("clamp", rd[`DDS_STAT_CLAMP_BIT], 1);
    conclude();
  end
endmodule // dds_core_test
